// ===== design/msd_fmt.sv
// Purpose: works out digit count and decimal point place for the display
// Assumes: value within the displayable range
// Notes: dp_index counts digits right of the point
`timescale 1ns/1ps
module msd_fmt (
  input logic clk_sys,
  input logic rst,
  msd_fmt_if.fmt_side f
);
  logic [31:0] mag;
  logic [3:0] val_dig, min_dig, dp_dig, shown_d, shown_q;
  logic [2:0] dp_idx_d, dp_idx_q;
  logic dp_on_d, dp_on_q;

  always_comb begin
    mag = (f.is_signed && f.value[31]) ? 32'(-f.value) : f.value;
    if (mag >= msd_pkg::DIG_FOUR) begin
      val_dig = 4'h4;
    end else if (mag >= msd_pkg::DIG_THREE) begin
      val_dig = 4'h3;
    end else if (mag >= msd_pkg::DIG_TWO) begin
      val_dig = 4'h2;
    end else begin
      val_dig = 4'h1;
    end
    min_dig = {1'b0, f.fmt[msd_pkg::FMT_MIN_LSB +: 3]};
    if (min_dig == 4'h0) begin
      min_dig = 4'h1;
    end
    dp_dig = {1'b0, f.fmt[msd_pkg::FMT_DP_LSB +: 3]} + 4'h1;
    if (f.fmt[msd_pkg::FMT_RIGHT_BIT]) begin
      dp_dig = 4'h1;
      dp_idx_d = 3'h0;
      dp_on_d = 1'b1;
    end else begin
      dp_idx_d = f.fmt[msd_pkg::FMT_DP_LSB +: 3];
      dp_on_d = (f.fmt[msd_pkg::FMT_DP_LSB +: 3] != 3'h0);
    end
    shown_d = val_dig;
    if (min_dig > shown_d) begin
      shown_d = min_dig;
    end
    if (dp_dig > shown_d) begin
      shown_d = dp_dig;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shown_q <= 4'h1;
      dp_idx_q <= 3'h0;
      dp_on_q <= 1'b0;
    end else begin
      shown_q <= shown_d;
      dp_idx_q <= dp_idx_d;
      dp_on_q <= dp_on_d;
    end
  end

  assign f.shown_digits = shown_q;
  assign f.dp_index = dp_idx_q;
  assign f.dp_on = dp_on_q;

  a_dp_right_forced: assert property (@(posedge clk_sys) disable iff (rst)
    f.fmt[msd_pkg::FMT_RIGHT_BIT] |=> (f.dp_on && f.dp_index == 3'h0))
    else $error("right point bit ignored");
  a_zero_before_dp: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> (f.shown_digits > {1'b0, f.dp_index}))
    else $error("no digit before decimal point");
endmodule

// ===== design/msd_fmt_if.sv
// Purpose: carries the displayed value and format word to the formatter
// Assumes: single clock domain
// Notes: results come back registered
`timescale 1ns/1ps
interface msd_fmt_if;
  logic [31:0] value;
  logic is_signed;
  logic [6:0] fmt;
  logic [3:0] shown_digits;
  logic [2:0] dp_index;
  logic dp_on;
  modport bank (output value, output is_signed, output fmt,
    input shown_digits, input dp_index, input dp_on);
  modport fmt_side (input value, input is_signed, input fmt,
    output shown_digits, output dp_index, output dp_on);
endinterface

// ===== design/msd_pkg.sv
// Purpose: constants shared by the display register bank and its formatter
// Assumes: 100 MHz clk_sys, requests already split per register by the frame layer
// Notes: register offsets are register numbers as seen on the link
package msd_pkg;
  localparam logic [15:0] REG_VAL_HI = 16'h0001;
  localparam logic [15:0] REG_VAL_LO = 16'h0002;
  localparam logic [15:0] REG_FMT = 16'h0003;
  localparam logic [15:0] REG_DEC4_ATTR = 16'h001B;
  localparam logic [15:0] REG_ADDR = 16'h0020;
  localparam logic [15:0] REG_ID = 16'h0021;
  localparam logic [15:0] REG_SPEED = 16'h0022;
  localparam logic [15:0] REG_PERMIT = 16'h0023;
  localparam logic [15:0] REG_DELAY = 16'h0025;
  localparam logic [15:0] REG_REPLY_MODE = 16'h0026;
  localparam logic [15:0] REG_GAP = 16'h0027;
  localparam logic [15:0] REG_LUM = 16'h002D;
  localparam logic [15:0] REG_EDIT = 16'h002F;
  localparam logic [15:0] REG_VFMT = 16'h0030;
  localparam logic [15:0] REG_VLUM = 16'h0031;

  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE_ONE = 8'h06;
  localparam logic [7:0] FN_WRITE_MANY = 8'h10;

  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_PERMIT = 8'h08;

  localparam logic [15:0] ADDR_MIN = 16'h0001;
  localparam logic [15:0] ADDR_MAX = 16'h00FF;
  localparam logic [15:0] SPEED_MAX = 16'h0007;
  localparam logic [15:0] FLAG_MAX = 16'h0001;
  localparam logic [15:0] DELAY_MAX = 16'h0005;
  localparam logic [15:0] GAP_MAX = 16'h0063;
  localparam logic [15:0] LUM_MIN = 16'h0001;
  localparam logic [15:0] LUM_MAX = 16'h0008;
  localparam logic [15:0] VFMT_MAX = 16'h0003;

  localparam logic [7:0] RST_ADDR = 8'h01;
  localparam logic [2:0] RST_SPEED = 3'h3;
  localparam logic [2:0] RST_DELAY = 3'h0;
  localparam logic [6:0] RST_GAP = 7'h00;
  localparam logic [3:0] RST_LUM = 4'h6;
  localparam logic [1:0] RST_VFMT = 2'h1;
  localparam logic [6:0] RST_FMT = 7'h00;

  localparam int VF_WIDE_BIT = 1;
  localparam int VF_SIGNED_BIT = 0;
  localparam int FMT_DP_LSB = 0;
  localparam int FMT_RIGHT_BIT = 3;
  localparam int FMT_MIN_LSB = 4;
  localparam int ATTR_BLINK_BIT = 12;

  localparam logic [31:0] DIG_TWO = 32'h0000000A;
  localparam logic [31:0] DIG_THREE = 32'h00000064;
  localparam logic [31:0] DIG_FOUR = 32'h000003E8;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned GAP_UNIT_S = 1;
  localparam int unsigned CYC_PER_SEC = CLK_HZ * GAP_UNIT_S;

  function automatic logic [16:0] baud_div(input logic [2:0] code);
    logic [16:0] d;
    d = 17'(CLK_HZ / 1200);
    case (code)
      3'h1: d = 17'(CLK_HZ / 2400);
      3'h2: d = 17'(CLK_HZ / 4800);
      3'h3: d = 17'(CLK_HZ / 9600);
      3'h4: d = 17'(CLK_HZ / 19200);
      3'h5: d = 17'(CLK_HZ / 38400);
      3'h6: d = 17'(CLK_HZ / 57600);
      3'h7: d = 17'(CLK_HZ / 115200);
      default: d = 17'(CLK_HZ / 1200);
    endcase
    return d;
  endfunction

  function automatic logic [7:0] delay_chars(input logic [2:0] code);
    logic [7:0] c;
    c = 8'h00;
    case (code)
      3'h1: c = 8'h0A;
      3'h2: c = 8'h14;
      3'h3: c = 8'h32;
      3'h4: c = 8'h64;
      3'h5: c = 8'hC8;
      default: c = 8'h00;
    endcase
    return c;
  endfunction
endpackage

// ===== design/msd_regs.sv
// Purpose: follower register bank of the serial display indicator
// Assumes: frame layer checks CRC, address match and hands over one register per request
// Notes: a frame is the run of requests up to and including req_last
`timescale 1ns/1ps
module msd_regs #(
  parameter int unsigned CYC_PER_SEC = msd_pkg::CYC_PER_SEC,
  // arbitrary identity value
  parameter logic [15:0] ID_CODE = 16'h5A5A
) (
  input logic clk_sys,
  input logic rst,
  input logic req_valid,
  input logic [7:0] req_func,
  input logic [15:0] req_addr,
  input logic [15:0] req_wdata,
  input logic req_last,
  input logic req_bcast,
  input logic follower_mode,
  input logic menu_permit_restore,
  output logic ack_valid,
  output logic [15:0] ack_rdata,
  output logic [7:0] ack_exc,
  output logic reply_valid,
  output logic reply_send,
  output logic [7:0] reply_exc,
  output logic [7:0] reply_addr,
  output logic [7:0] bus_address,
  output logic [2:0] link_speed,
  output logic [16:0] baud_div,
  output logic [7:0] reply_delay_chars,
  output logic write_permit,
  output logic edit_ramp,
  output logic [1:0] value_format,
  output logic [3:0] luminance,
  output logic [31:0] display_value,
  output logic decade4_blink,
  output logic frame_timeout,
  output logic [3:0] shown_digits,
  output logic [2:0] dp_index,
  output logic dp_on
);
  ////////////////////////////////////////////////////////////////////////////
  // configuration state
  logic [7:0] addr_q, addr_d;
  logic [2:0] speed_q, speed_d, delay_q, delay_d;
  logic permit_q, permit_d, rmode_q, rmode_d, edit_q, edit_d;
  logic [6:0] gap_q, gap_d, fmt_q, fmt_d;
  logic [3:0] lum_q, lum_d, vlum_q, vlum_d;
  logic vlum_set_q, vlum_set_d;
  logic [1:0] vfmt_q, vfmt_d;
  logic [15:0] attr_q, attr_d, hi_q, hi_d;
  logic [31:0] val_q, val_d;
  logic blink_q, blink_d;

  // per-request decode
  logic func_ok, is_wr, mapped, in_range, wr_en, disp_reg;
  logic [7:0] exc;
  logic [15:0] rdata;

  always_comb begin
    func_ok = (req_func == msd_pkg::FN_READ) || (req_func == msd_pkg::FN_WRITE_ONE) ||
              (req_func == msd_pkg::FN_WRITE_MANY);
    is_wr = (req_func == msd_pkg::FN_WRITE_ONE) || (req_func == msd_pkg::FN_WRITE_MANY);
    disp_reg = (req_addr == msd_pkg::REG_VAL_HI) || (req_addr == msd_pkg::REG_VAL_LO) ||
               (req_addr == msd_pkg::REG_FMT);
    mapped = 1'b1;
    in_range = 1'b1;
    rdata = 16'h0000;
    case (req_addr)
      msd_pkg::REG_VAL_HI: rdata = val_q[31:16];
      msd_pkg::REG_VAL_LO: rdata = val_q[15:0];
      msd_pkg::REG_FMT: rdata = {9'h000, fmt_q};
      msd_pkg::REG_DEC4_ATTR: rdata = attr_q;
      msd_pkg::REG_ADDR: begin
        rdata = {8'h00, addr_q};
        in_range = (req_wdata >= msd_pkg::ADDR_MIN) && (req_wdata <= msd_pkg::ADDR_MAX);
      end
      msd_pkg::REG_ID: rdata = ID_CODE;
      msd_pkg::REG_SPEED: begin
        rdata = {13'h0000, speed_q};
        in_range = (req_wdata <= msd_pkg::SPEED_MAX);
      end
      msd_pkg::REG_PERMIT: begin
        rdata = {15'h0000, permit_q};
        in_range = (req_wdata == 16'h0000);
      end
      msd_pkg::REG_DELAY: begin
        rdata = {13'h0000, delay_q};
        in_range = (req_wdata <= msd_pkg::DELAY_MAX);
      end
      msd_pkg::REG_REPLY_MODE: begin
        rdata = {15'h0000, rmode_q};
        in_range = (req_wdata <= msd_pkg::FLAG_MAX);
      end
      msd_pkg::REG_GAP: begin
        rdata = {9'h000, gap_q};
        in_range = (req_wdata <= msd_pkg::GAP_MAX);
      end
      msd_pkg::REG_LUM: begin
        rdata = {12'h000, lum_q};
        in_range = (req_wdata >= msd_pkg::LUM_MIN) && (req_wdata <= msd_pkg::LUM_MAX);
      end
      msd_pkg::REG_EDIT: begin
        rdata = {15'h0000, edit_q};
        in_range = (req_wdata <= msd_pkg::FLAG_MAX);
      end
      msd_pkg::REG_VFMT: begin
        rdata = {14'h0000, vfmt_q};
        in_range = (req_wdata <= msd_pkg::VFMT_MAX);
      end
      msd_pkg::REG_VLUM: begin
        rdata = {12'h000, vlum_q};
        in_range = (req_wdata >= msd_pkg::LUM_MIN) && (req_wdata <= msd_pkg::LUM_MAX);
      end
      default: mapped = 1'b0;
    endcase
    if (!func_ok) begin
      exc = msd_pkg::EXC_FUNC;
    end else if (!mapped || (is_wr && req_addr == msd_pkg::REG_ID)) begin
      exc = msd_pkg::EXC_ADDR;
    end else if (is_wr && !permit_q) begin
      exc = msd_pkg::EXC_PERMIT;
    end else if (is_wr && !in_range) begin
      exc = msd_pkg::EXC_VALUE;
    end else begin
      exc = msd_pkg::EXC_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame tracking; a fault stops later writes of the same frame
  logic busy_q, busy_d, touch_q, touch_d, quiet;
  logic [7:0] fexc_q, fexc_d, cur_fexc, start_addr;
  logic ack_v_d, rep_v_d, rep_s_d;
  logic [15:0] ack_r_d;
  logic [7:0] ack_e_d, rep_e_d, rep_a_d;
  logic ack_v_q, rep_v_q, rep_s_q;
  logic [15:0] ack_r_q;
  logic [7:0] ack_e_q, rep_e_q, rep_a_q;

  always_comb begin
    cur_fexc = busy_q ? fexc_q : msd_pkg::EXC_NONE;
    // reply uses address from frame start
    start_addr = busy_q ? rep_a_q : addr_q;
    wr_en = req_valid && is_wr && (exc == msd_pkg::EXC_NONE) &&
            (cur_fexc == msd_pkg::EXC_NONE);
    busy_d = busy_q;
    fexc_d = fexc_q;
    touch_d = touch_q;
    rep_a_d = rep_a_q;
    if (req_valid) begin
      busy_d = !req_last;
      fexc_d = (cur_fexc == msd_pkg::EXC_NONE) ? exc : cur_fexc;
      touch_d = (busy_q && touch_q) || (wr_en && disp_reg);
      rep_a_d = start_addr;
    end
    quiet = touch_d && !rmode_q && (fexc_d == msd_pkg::EXC_NONE);
    ack_v_d = req_valid;
    ack_r_d = (req_valid && exc == msd_pkg::EXC_NONE) ? rdata : 16'h0000;
    ack_e_d = req_valid ? exc : msd_pkg::EXC_NONE;
    rep_v_d = req_valid && req_last;
    rep_s_d = req_valid && req_last && !req_bcast && !quiet;
    rep_e_d = (req_valid && req_last) ? fexc_d : rep_e_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_q <= 1'b0;
      fexc_q <= msd_pkg::EXC_NONE;
      touch_q <= 1'b0;
      ack_v_q <= 1'b0;
      ack_r_q <= 16'h0000;
      ack_e_q <= msd_pkg::EXC_NONE;
      rep_v_q <= 1'b0;
      rep_s_q <= 1'b0;
      rep_e_q <= msd_pkg::EXC_NONE;
      rep_a_q <= msd_pkg::RST_ADDR;
    end else begin
      busy_q <= busy_d;
      fexc_q <= fexc_d;
      touch_q <= touch_d;
      ack_v_q <= ack_v_d;
      ack_r_q <= ack_r_d;
      ack_e_q <= ack_e_d;
      rep_v_q <= rep_v_d;
      rep_s_q <= rep_s_d;
      rep_e_q <= rep_e_d;
      rep_a_q <= rep_a_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_comb begin
    addr_d = addr_q;
    speed_d = speed_q;
    delay_d = delay_q;
    rmode_d = rmode_q;
    gap_d = gap_q;
    lum_d = lum_q;
    edit_d = edit_q;
    vfmt_d = vfmt_q;
    vlum_d = vlum_q;
    vlum_set_d = vlum_set_q;
    fmt_d = fmt_q;
    attr_d = attr_q;
    hi_d = hi_q;
    val_d = val_q;
    permit_d = permit_q || menu_permit_restore;
    if (wr_en) begin
      case (req_addr)
        msd_pkg::REG_ADDR: addr_d = req_wdata[7:0];
        msd_pkg::REG_SPEED: speed_d = req_wdata[2:0];
        msd_pkg::REG_PERMIT: permit_d = menu_permit_restore;
        msd_pkg::REG_DELAY: delay_d = req_wdata[2:0];
        msd_pkg::REG_REPLY_MODE: rmode_d = req_wdata[0];
        msd_pkg::REG_GAP: gap_d = req_wdata[6:0];
        msd_pkg::REG_LUM: lum_d = req_wdata[3:0];
        msd_pkg::REG_EDIT: edit_d = req_wdata[0];
        msd_pkg::REG_VFMT: vfmt_d = req_wdata[1:0];
        msd_pkg::REG_VLUM: begin
          vlum_d = req_wdata[3:0];
          vlum_set_d = 1'b1;
        end
        msd_pkg::REG_FMT: fmt_d = req_wdata[6:0];
        msd_pkg::REG_DEC4_ATTR: attr_d = req_wdata;
        msd_pkg::REG_VAL_HI: hi_d = req_wdata;
        msd_pkg::REG_VAL_LO: begin
          if (vfmt_q[msd_pkg::VF_WIDE_BIT]) begin
            val_d = {hi_q, req_wdata};
          end else if (vfmt_q[msd_pkg::VF_SIGNED_BIT]) begin
            val_d = {{16{req_wdata[15]}}, req_wdata};
          end else begin
            val_d = {16'h0000, req_wdata};
          end
        end
        default: addr_d = addr_q;
      endcase
    end
    blink_d = attr_q[msd_pkg::ATTR_BLINK_BIT] && follower_mode;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_q <= msd_pkg::RST_ADDR;
      speed_q <= msd_pkg::RST_SPEED;
      permit_q <= 1'b1;
      delay_q <= msd_pkg::RST_DELAY;
      rmode_q <= 1'b1;
      gap_q <= msd_pkg::RST_GAP;
      lum_q <= msd_pkg::RST_LUM;
      edit_q <= 1'b0;
      vfmt_q <= msd_pkg::RST_VFMT;
      vlum_q <= 4'h0;
      vlum_set_q <= 1'b0;
      fmt_q <= msd_pkg::RST_FMT;
      attr_q <= 16'h0000;
      hi_q <= 16'h0000;
      val_q <= 32'h00000000;
      blink_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      speed_q <= speed_d;
      permit_q <= permit_d;
      delay_q <= delay_d;
      rmode_q <= rmode_d;
      gap_q <= gap_d;
      lum_q <= lum_d;
      edit_q <= edit_d;
      vfmt_q <= vfmt_d;
      vlum_q <= vlum_d;
      vlum_set_q <= vlum_set_d;
      fmt_q <= fmt_d;
      attr_q <= attr_d;
      hi_q <= hi_d;
      val_q <= val_d;
      blink_q <= blink_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame gap supervision; second count saturates so long idles stay flagged
  logic [26:0] cyc_q, cyc_d;
  logic [6:0] sec_q, sec_d;
  logic tmo_q, tmo_d, frame_end;

  always_comb begin
    frame_end = req_valid && req_last;
    cyc_d = cyc_q;
    sec_d = sec_q;
    tmo_d = tmo_q;
    if (frame_end) begin
      cyc_d = 27'h0000000;
      sec_d = 7'h00;
      tmo_d = 1'b0;
    end else begin
      if (cyc_q == 27'(CYC_PER_SEC - 1)) begin
        cyc_d = 27'h0000000;
        if (sec_q != 7'h7F) begin
          sec_d = sec_q + 7'h01;
        end
      end else begin
        cyc_d = cyc_q + 27'h0000001;
      end
      if (gap_q != 7'h00 && sec_q >= gap_q) begin
        tmo_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cyc_q <= 27'h0000000;
      sec_q <= 7'h00;
      tmo_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      sec_q <= sec_d;
      tmo_q <= tmo_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // formatter and outputs
  msd_fmt_if fmt_bus ();
  assign fmt_bus.value = val_q;
  assign fmt_bus.is_signed = vfmt_q[msd_pkg::VF_SIGNED_BIT];
  assign fmt_bus.fmt = fmt_q;

  msd_fmt u_fmt (
    .clk_sys(clk_sys),
    .rst(rst),
    .f(fmt_bus.fmt_side)
  );

  assign ack_valid = ack_v_q;
  assign ack_rdata = ack_r_q;
  assign ack_exc = ack_e_q;
  assign reply_valid = rep_v_q;
  assign reply_send = rep_s_q;
  assign reply_exc = rep_e_q;
  assign reply_addr = rep_a_q;
  assign bus_address = addr_q;
  assign link_speed = speed_q;
  assign baud_div = msd_pkg::baud_div(speed_q);
  assign reply_delay_chars = msd_pkg::delay_chars(delay_q);
  assign write_permit = permit_q;
  assign edit_ramp = edit_q;
  assign value_format = vfmt_q;
  assign luminance = vlum_set_q ? vlum_q : lum_q;
  assign display_value = val_q;
  assign decade4_blink = blink_q;
  assign frame_timeout = tmo_q;
  assign shown_digits = fmt_bus.shown_digits;
  assign dp_index = fmt_bus.dp_index;
  assign dp_on = fmt_bus.dp_on;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_single_write(logic [15:0] ra);
    req_valid && req_last && !busy_q && is_wr && req_addr == ra && permit_q;
  endsequence

  a_old_addr_reply: assert property (s_single_write(msd_pkg::REG_ADDR) |=>
    reply_valid && reply_addr == $past(addr_q)) else $error("reply used new address");
  a_speed_applies: assert property ((s_single_write(msd_pkg::REG_SPEED) ##0
    req_wdata <= msd_pkg::SPEED_MAX) |=> reply_valid && link_speed == $past(req_wdata[2:0]))
    else $error("speed not ready for reply");
  a_speed_reject: assert property ((s_single_write(msd_pkg::REG_SPEED) ##0
    req_wdata > msd_pkg::SPEED_MAX) |=> $stable(link_speed) && ack_exc == msd_pkg::EXC_VALUE)
    else $error("bad speed taken");
  a_permit_no_set: assert property (!write_permit && !menu_permit_restore |=>
    !write_permit) else $error("permit set from link");
  a_permit_refuse: assert property (req_valid && req_func == msd_pkg::FN_WRITE_ONE &&
    req_addr == msd_pkg::REG_LUM && !permit_q |=> ack_exc == msd_pkg::EXC_PERMIT &&
    $stable(lum_q)) else $error("write without permit");
  a_bad_function: assert property (req_valid && !func_ok |=> ack_valid &&
    ack_exc == msd_pkg::EXC_FUNC) else $error("bad function not refused");
  a_quiet_disp: assert property ((s_single_write(msd_pkg::REG_FMT) ##0 !rmode_q)
    |=> reply_valid && !reply_send) else $error("display write answered");
  a_lum_bounds: assert property (luminance >= 4'h1 && luminance <= 4'h8)
    else $error("stored brightness out of range");
  a_timeout_cause: assert property ($rose(frame_timeout) |-> $past(gap_q) != 7'h00 &&
    $past(sec_q) >= $past(gap_q)) else $error("timeout without gap");
  a_timeout_clear: assert property (req_valid && req_last |=> !frame_timeout)
    else $error("timeout stuck after frame");
  a_blink_gate: assert property (decade4_blink |-> $past(follower_mode))
    else $error("blink outside follower mode");
endmodule

// ===== testbench/msd_master.sv
// Purpose: bus master stand-in, one register request per frame
// Assumes: device frame layer has split the frame into registers
// Notes: released fields show the inverse of the last value
`timescale 1ns/1ps
module msd_master (
  input wire logic clk_sys,
  output logic req_valid,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata,
  output logic req_last,
  output logic req_bcast
);
  initial begin
    req_valid = 1'b0;
    req_last = 1'b0;
    req_bcast = 1'b0;
    req_func = 8'hFF;
    req_addr = 16'hFFFF;
    req_wdata = 16'hFFFF;
  end
  ////////////////////////////////////////
  // whole register requests
  task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
    input logic b = 1'b0);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_bcast <= b;
    req_func <= f;
    req_addr <= a;
    req_wdata <= d;
    req_last <= 1'b1;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    req_last <= 1'b0;
    req_bcast <= 1'b0;
    req_func <= ~f;
    req_addr <= ~a;
    req_wdata <= ~d;
    #1;
  endtask
endmodule

// ===== testbench/tb.sv
// Purpose: self-checking bench for the display register bank
// Assumes: one register per frame, follower mode held on except while the blink check drops it
// Notes: a second is 20 cycles here so the gap check stays short
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic menu_permit_restore = 1'b0;
  logic req_valid, req_last, req_bcast, ack_valid, reply_send, write_permit, frame_timeout;
  logic [7:0] req_func, ack_exc, reply_addr, bus_address;
  logic [15:0] req_addr, req_wdata, ack_rdata;
  logic [2:0] link_speed, dp_index;
  logic [16:0] baud_div;
  logic [1:0] value_format;
  logic [3:0] luminance, shown_digits;
  logic reply_valid, edit_ramp, decade4_blink, dp_on;
  logic follower_mode = 1'b1;
  logic [7:0] reply_exc, reply_delay_chars;
  logic [31:0] display_value;
  int num_errors = 0;
  int check_count = 0;
  int rates[8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  always #5 clk_sys = ~clk_sys;
  msd_master m_master (.clk_sys, .req_valid, .req_func, .req_addr, .req_wdata, .req_last,
    .req_bcast);
  msd_regs #(.CYC_PER_SEC(20), .ID_CODE(16'h1234)) i_msd_regs (.clk_sys, .rst, .req_valid,
    .req_func, .req_addr, .req_wdata, .req_last, .req_bcast, .follower_mode,
    .menu_permit_restore, .ack_valid, .ack_rdata, .ack_exc, .reply_valid, .reply_send,
    .reply_exc, .reply_addr, .bus_address, .link_speed, .baud_div, .reply_delay_chars,
    .write_permit, .edit_ramp, .value_format, .luminance, .display_value,
    .decade4_blink, .frame_timeout, .shown_digits, .dp_index, .dp_on);
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
    input logic [7:0] exc);
    m_master.send(f, a, d);
    check("ack_valid", ack_valid, 32'h1);
    check("ack_exc", ack_exc, exc);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_codes;
    check("bus_address", bus_address, 32'h01);
    check("luminance", luminance, 32'h6);
    wr(8'h03, 16'h0021, 16'h0000, 8'h00);
    check("ack_rdata", ack_rdata, 32'h1234);
    m_master.send(8'h03, 16'h0021, 16'h0000, 1'b1);
    check("reply_valid", reply_valid, 32'h1);
    check("reply_send", reply_send, 32'h0);
    wr(8'h04, 16'h0021, 16'h0000, 8'h01);
    check("reply_exc", reply_exc, 32'h01);
    wr(8'h06, 16'h0021, 16'h0001, 8'h02);
    wr(8'h10, 16'h0024, 16'h0001, 8'h02);
    wr(8'h06, 16'h0020, 16'h0002, 8'h00);
    check("reply_addr", reply_addr, 32'h01);
    check("bus_address", bus_address, 32'h02);
    wr(8'h06, 16'h0020, 16'h0000, 8'h03);
    $display("test codes and address done");
  endtask
  task automatic t_speed_lum;
    for (int i = 0; i < 8; i++) begin
      wr(8'h06, 16'h0022, 16'(i), 8'h00);
      check("baud_div", baud_div, 32'(100000000 / rates[i]));
      check("link_speed", link_speed, 32'(i));
    end
    wr(8'h06, 16'h002F, 16'h0001, 8'h00);
    check("edit_ramp", edit_ramp, 32'h1);
    wr(8'h06, 16'h0022, 16'h0008, 8'h03);
    wr(8'h06, 16'h002D, 16'h0009, 8'h03);
    wr(8'h06, 16'h002D, 16'h0008, 8'h00);
    check("luminance", luminance, 32'h8);
    wr(8'h06, 16'h0031, 16'h0002, 8'h00);
    check("luminance", luminance, 32'h2);
    $display("test speed and brightness done");
  endtask
  task automatic t_reply_gap;
    wr(8'h06, 16'h0026, 16'h0000, 8'h00);
    wr(8'h06, 16'h0003, 16'h0000, 8'h00);
    check("reply_valid", reply_valid, 32'h1);
    check("reply_send", reply_send, 32'h0);
    wr(8'h06, 16'h0002, 16'h0005, 8'h00);
    check("reply_send", reply_send, 32'h0);
    wr(8'h06, 16'h0026, 16'h0001, 8'h00);
    check("reply_send", reply_send, 32'h1);
    wr(8'h06, 16'h0002, 16'h0005, 8'h00);
    check("reply_send", reply_send, 32'h1);
    wr(8'h06, 16'h0025, 16'h0005, 8'h00);
    check("reply_delay_chars", reply_delay_chars, 32'hC8);
    wr(8'h06, 16'h0025, 16'h0006, 8'h03);
    wr(8'h06, 16'h0027, 16'h0064, 8'h03);
    wr(8'h06, 16'h0027, 16'h0002, 8'h00);
    repeat (30) @(posedge clk_sys);
    #1;
    check("frame_timeout", frame_timeout, 32'h0);
    repeat (20) @(posedge clk_sys);
    #1;
    check("frame_timeout", frame_timeout, 32'h1);
    wr(8'h03, 16'h0027, 16'h0000, 8'h00);
    check("ack_rdata", ack_rdata, 32'h2);
    @(posedge clk_sys);
    #1;
    check("frame_timeout", frame_timeout, 32'h0);
    $display("test reply and gap done");
  endtask
  task automatic t_permit;
    wr(8'h06, 16'h0023, 16'h0001, 8'h03);
    wr(8'h06, 16'h0023, 16'h0000, 8'h00);
    check("write_permit", write_permit, 32'h0);
    wr(8'h06, 16'h002F, 16'h0001, 8'h08);
    wr(8'h06, 16'h002D, 16'h0003, 8'h08);
    wr(8'h06, 16'h0023, 16'h0001, 8'h08);
    check("write_permit", write_permit, 32'h0);
    wr(8'h03, 16'h0023, 16'h0000, 8'h00);
    check("ack_rdata", ack_rdata, 32'h0);
    @(posedge clk_sys);
    menu_permit_restore <= 1'b1;
    @(posedge clk_sys);
    menu_permit_restore <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("write_permit", write_permit, 32'h1);
    $display("test permit done");
  endtask
  task automatic t_display;
    wr(8'h06, 16'h0003, 16'h0002, 8'h00);
    wr(8'h06, 16'h0002, 16'h0001, 8'h00);
    check("display_value", display_value, 32'h1);
    check("value_format", value_format, 32'h1);
    @(posedge clk_sys);
    #1;
    check("shown_digits", shown_digits, 32'h3);
    check("dp_index", dp_index, 32'h2);
    check("dp_on", dp_on, 32'h1);
    wr(8'h06, 16'h0003, 16'h0040, 8'h00);
    @(posedge clk_sys);
    #1;
    check("shown_digits", shown_digits, 32'h4);
    check("dp_on", dp_on, 32'h0);
    wr(8'h06, 16'h0003, 16'h0028, 8'h00);
    @(posedge clk_sys);
    #1;
    check("shown_digits", shown_digits, 32'h2);
    check("dp_on", dp_on, 32'h1);
    check("dp_index", dp_index, 32'h0);
    wr(8'h06, 16'h0030, 16'h0004, 8'h03);
    wr(8'h06, 16'h0030, 16'h0002, 8'h00);
    wr(8'h06, 16'h0001, 16'h0001, 8'h00);
    check("display_value", display_value, 32'h1);
    wr(8'h06, 16'h0002, 16'h0000, 8'h00);
    check("display_value", display_value, 32'h10000);
    wr(8'h06, 16'h0030, 16'h0001, 8'h00);
    wr(8'h06, 16'h0002, 16'hFFFF, 8'h00);
    check("display_value", display_value, 32'hFFFFFFFF);
    wr(8'h06, 16'h001B, 16'h1000, 8'h00);
    @(posedge clk_sys);
    #1;
    check("decade4_blink", decade4_blink, 32'h1);
    @(posedge clk_sys);
    follower_mode <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("decade4_blink", decade4_blink, 32'h0);
    @(posedge clk_sys);
    follower_mode <= 1'b1;
    $display("test display format done");
  endtask
  task automatic t_reset;
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("luminance", luminance, 32'h6);
    check("bus_address", bus_address, 32'h01);
    $display("test reset done");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    t_codes;
    t_speed_lum;
    t_reply_gap;
    t_permit;
    t_display;
    t_reset;
    final_report;
  end
  // run needs well under a thousand cycles
  initial begin
    #100000;
    num_errors++;
    final_report;
  end
endmodule
